// *** logic/tsb_pkg.sv ***
// Constants and types for the transmit slip buffer with its status registers
package tsb_pkg;

  // Elastic store geometry: two frames of bytes
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FRAME_LEN  = 32;
  localparam int unsigned DEPTH      = 2 * FRAME_LEN;
  localparam int unsigned ADDR_W     = $clog2(DEPTH);
  localparam int unsigned PTR_W      = ADDR_W + 1;

  // Avalon-MM register map, byte addresses
  localparam int unsigned BUS_ADDR_W = 4;
  localparam logic [BUS_ADDR_W-1:0] OFS_IRQ_STATUS = 4'h0;
  localparam logic [BUS_ADDR_W-1:0] OFS_IRQ_MASK   = 4'h4;
  localparam logic [BUS_ADDR_W-1:0] OFS_LEVEL      = 4'h8;

  // Status and mask bit positions
  localparam int unsigned BIT_FULL  = 7;
  localparam int unsigned BIT_EMPTY = 6;
  localparam int unsigned BIT_SLIP  = 5;

  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET   = 8'h00;
  localparam logic [7:0]  EVENT_BITS   = 8'he0;

  // Slip events from the store, one-cycle pulses
  typedef struct packed {
    logic full;
    logic empty;
  } tsb_evt_s;

  // Register bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } tsb_bus_e;

endpackage : tsb_pkg

// *** logic/tsb_store.sv ***
// Two-frame elastic store with frame deletion on overflow and frame replay on underflow
module tsb_store (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Backplane write side
  input  wire logic                          wr_en,
  input  wire logic [tsb_pkg::DATA_W-1:0]    wr_data,
  // Line read side
  input  wire logic                          rd_en,
  output logic      [tsb_pkg::DATA_W-1:0]    rd_data,
  output logic                               rd_valid,
  // Status
  output logic      [tsb_pkg::PTR_W-1:0]     level,
  output tsb_pkg::tsb_evt_s                  evt
);

  localparam logic [tsb_pkg::PTR_W-1:0] FRAME_P = tsb_pkg::PTR_W'(tsb_pkg::FRAME_LEN);
  localparam logic [tsb_pkg::PTR_W-1:0] DEPTH_P = tsb_pkg::PTR_W'(tsb_pkg::DEPTH);

  logic [tsb_pkg::DATA_W-1:0] mem [tsb_pkg::DEPTH];
  logic [tsb_pkg::PTR_W-1:0]  wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [tsb_pkg::PTR_W-1:0]  rd_base, count;
  logic [tsb_pkg::DATA_W-1:0] rd_data_q, rd_data_d;
  logic                       rd_valid_q, rd_valid_d;
  tsb_pkg::tsb_evt_s          evt_q, evt_d;
  logic                       is_full, is_empty;

  assign count    = wr_ptr_q - rd_ptr_q;
  assign is_full  = (count == DEPTH_P);
  assign is_empty = (count == '0);

  always_comb begin
    wr_ptr_d   = wr_ptr_q;
    rd_base    = rd_ptr_q;
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_q;
    evt_d      = '0;
    // Overflow: drop the oldest whole frame to make room
    if (wr_en && is_full) begin
      rd_base    = rd_ptr_q + FRAME_P;
      evt_d.full = 1'b1;
    end
    // Underflow: step back one whole frame and send it again
    if (rd_en && is_empty) begin
      rd_base     = rd_ptr_q - FRAME_P;
      evt_d.empty = 1'b1;
    end
    rd_ptr_d = rd_base;
    if (wr_en) begin
      wr_ptr_d = wr_ptr_q + 1'b1;
    end
    if (rd_en) begin
      rd_data_d  = mem[rd_base[tsb_pkg::ADDR_W-1:0]];
      rd_valid_d = 1'b1;
      rd_ptr_d   = rd_base + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_ptr_q[tsb_pkg::ADDR_W-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
      evt_q      <= '0;
    end else begin
      wr_ptr_q   <= wr_ptr_d;
      rd_ptr_q   <= rd_ptr_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      evt_q      <= evt_d;
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign level    = count;
  assign evt      = evt_q;

endmodule : tsb_store

// *** logic/tsb_top.sv ***
// Transmit slip buffer with read-clear slip status, interrupt mask and Avalon-MM slave
// Function
// - Write into full store deletes one whole frame and sets full flag, bit 7.
// - Read from empty store repeats one whole frame and sets empty flag, bit 6.
// - Either deletion or repetition sets the slip flag, bit 5.
// - Flags show events since last status read and clear when read.
module tsb_top (
  // Clock and reset
  input  wire logic                              REF_CLK,
  input  wire logic                              SRST,
  // Avalon-MM slave
  input  wire logic [tsb_pkg::BUS_ADDR_W-1:0]    AVS_ADDRESS,
  input  wire logic                              AVS_READ,
  input  wire logic                              AVS_WRITE,
  input  wire logic [31:0]                       AVS_WRITEDATA,
  input  wire logic [3:0]                        AVS_BYTEENABLE,
  output logic      [31:0]                       AVS_READDATA,
  output logic                                   AVS_WAITREQUEST,
  // Backplane write side
  input  wire logic                              TX_WR_EN,
  input  wire logic [tsb_pkg::DATA_W-1:0]        TX_WR_DATA,
  // Line read side
  input  wire logic                              TX_RD_EN,
  output logic      [tsb_pkg::DATA_W-1:0]        TX_RD_DATA,
  output logic                                   TX_RD_VALID,
  // Interrupt
  output logic                                   IRQ
);

  tsb_pkg::tsb_bus_e           bus_q, bus_d;
  logic                        wait_q, wait_d;
  logic [31:0]                 rdata_q, rdata_d;
  logic [7:0]                  status_q, status_d;
  logic [7:0]                  mask_q, mask_d;
  logic [7:0]                  read_clr_q, read_clr_d;
  logic [7:0]                  set_bits, clr_bits;
  logic                        irq_q, irq_d;
  logic [tsb_pkg::PTR_W-1:0]   level;
  tsb_pkg::tsb_evt_s           evt;
  logic                        req, commit;

  tsb_store u_store (
    .clk      (REF_CLK),
    .srst     (SRST),
    .wr_en    (TX_WR_EN),
    .wr_data  (TX_WR_DATA),
    .rd_en    (TX_RD_EN),
    .rd_data  (TX_RD_DATA),
    .rd_valid (TX_RD_VALID),
    .level    (level),
    .evt      (evt)
  );

  assign req    = AVS_READ || AVS_WRITE;
  assign commit = req && (bus_q == tsb_pkg::BUS_ACK);

  // Bus handshake: sample on first edge, answer with waitrequest low for one cycle
  always_comb begin
    bus_d      = bus_q;
    wait_d     = 1'b1;
    rdata_d    = rdata_q;
    read_clr_d = read_clr_q;
    case (bus_q)
      tsb_pkg::BUS_IDLE: begin
        if (req) begin
          bus_d      = tsb_pkg::BUS_ACK;
          wait_d     = 1'b0;
          rdata_d    = '0;
          read_clr_d = '0;
          if (AVS_READ) begin
            if (AVS_ADDRESS == tsb_pkg::OFS_IRQ_STATUS) begin
              rdata_d[7:0] = status_q;
              read_clr_d   = status_q;
            end else if (AVS_ADDRESS == tsb_pkg::OFS_IRQ_MASK) begin
              rdata_d[7:0] = mask_q;
            end else if (AVS_ADDRESS == tsb_pkg::OFS_LEVEL) begin
              rdata_d[tsb_pkg::PTR_W-1:0] = level;
            end else begin
              rdata_d = '0;
            end
          end
        end
      end
      tsb_pkg::BUS_ACK: begin
        bus_d = tsb_pkg::BUS_IDLE;
      end
      default: begin
        bus_d = tsb_pkg::BUS_IDLE;
      end
    endcase
  end

  // Sticky slip flags: set wins over any clear in the same cycle
  always_comb begin
    set_bits                    = '0;
    set_bits[tsb_pkg::BIT_FULL]  = evt.full;
    set_bits[tsb_pkg::BIT_EMPTY] = evt.empty;
    set_bits[tsb_pkg::BIT_SLIP]  = evt.full || evt.empty;
    clr_bits = '0;
    if (commit && AVS_READ) begin
      // Only bits that were reported are cleared
      clr_bits = read_clr_q;
    end else if (commit && AVS_WRITE && AVS_ADDRESS == tsb_pkg::OFS_IRQ_STATUS && AVS_BYTEENABLE[0]) begin
      clr_bits = AVS_WRITEDATA[7:0];
    end
    status_d = ((status_q & ~clr_bits) | set_bits) & tsb_pkg::EVENT_BITS;
    mask_d   = mask_q;
    if (commit && AVS_WRITE && AVS_ADDRESS == tsb_pkg::OFS_IRQ_MASK && AVS_BYTEENABLE[0]) begin
      mask_d = AVS_WRITEDATA[7:0] & tsb_pkg::EVENT_BITS;
    end
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      bus_q      <= tsb_pkg::BUS_IDLE;
      wait_q     <= 1'b1;
      rdata_q    <= '0;
      read_clr_q <= '0;
      status_q   <= tsb_pkg::STATUS_RESET;
      mask_q     <= tsb_pkg::MASK_RESET;
      irq_q      <= 1'b0;
    end else begin
      bus_q      <= bus_d;
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      read_clr_q <= read_clr_d;
      status_q   <= status_d;
      mask_q     <= mask_d;
      irq_q      <= irq_d;
    end
  end

  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ             = irq_q;

endmodule : tsb_top

// *** testbench/tsb_monitor.sv ***
// Port-level checks of the slip buffer bus, strobes and interrupt
module tsb_monitor (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Watched ports
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic TX_WR_EN,
  input wire logic TX_RD_EN,
  input wire logic TX_RD_VALID,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act;
  logic rw;
  assign act = TX_WR_EN || TX_RD_EN || AVS_WRITE;
  assign rw  = AVS_READ || AVS_WRITE;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  property p_rst_clear;
    $fell(SRST) |-> !IRQ && AVS_WAITREQUEST;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("irq or ack set after reset");
  property p_irq_rise;
    $rose(IRQ) |-> $past(act) || $past(act, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without a cause");
  property p_irq_fall;
    $fell(IRQ) |-> $past(rw) || $past(rw, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without an access");
  property p_ack_one;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ack_bound;
    rw && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("ack late");
  property p_rd_valid;
    TX_RD_VALID == $past(TX_RD_EN);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid misplaced");
  c_irq_rise: cover property ($rose(IRQ));
  c_irq_fall: cover property ($fell(IRQ));
  c_rd_run: cover property (TX_RD_EN && TX_RD_VALID);
endmodule : tsb_monitor

bind tsb_top tsb_monitor tsb_monitor_inst (.REF_CLK, .SRST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
  .TX_WR_EN, .TX_RD_EN, .TX_RD_VALID, .IRQ);

// *** testbench/tsb_bp_model.sv ***
// Backplane writer model streaming bytes into the store
module tsb_bp_model (
  // Clock
  input wire logic clk,
  // Write side
  output logic       wr_en,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    wr_data = 8'h00;
  end
  task automatic send(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      wr_en <= 1'b1;
      wr_data <= 8'(base + i);
      @(posedge clk);
    end
    wr_en <= 1'b0;
    // Idle data carries no meaning
    wr_data <= ~wr_data;
  endtask : send
endmodule : tsb_bp_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the transmit slip buffer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ST = tsb_pkg::OFS_IRQ_STATUS;
  localparam logic [3:0] MK = tsb_pkg::OFS_IRQ_MASK;
  localparam logic [3:0] LV = tsb_pkg::OFS_LEVEL;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic        rd_en = 1'b0;
  logic [31:0] rdat;
  logic [31:0] d;
  logic        wreq, irq, rvld, wen;
  logic [7:0]  wbyte, rbyte;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
  always #5 clk = ~clk;
  tsb_top tsb_top_inst (.REF_CLK(clk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .TX_WR_EN(wen), .TX_WR_DATA(wbyte), .TX_RD_EN(rd_en), .TX_RD_DATA(rbyte), .TX_RD_VALID(rvld), .IRQ(irq));
  tsb_bp_model tsb_bp_model_inst (.clk(clk), .wr_en(wen), .wr_data(wbyte));
  task automatic av_rd(input logic [3:0] a, output logic [31:0] q);
    rd <= 1'b1;
    adr <= a;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    @(posedge clk);
  endtask : av_rd
  task automatic av_wr(input logic [3:0] a, input logic [7:0] v);
    wr <= 1'b1;
    adr <= a;
    wdat <= {24'h0, v};
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
    @(posedge clk);
  endtask : av_wr
  task automatic chk_rd(input string n, input logic [3:0] a, input logic [7:0] e);
    av_rd(a, d);
    `CHK(n, {24'h0, e}, d)
  endtask : chk_rd
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk_rd("status", ST, 8'h00);
    chk_rd("mask", MK, 8'h00);
    chk_rd("unmapped", 4'hc, 8'h00);
    $display("reset test done");
    av_wr(MK, 8'he0);
    tsb_bp_model_inst.send(64, 0);
    repeat (3) @(posedge clk);
    chk_rd("no slip", ST, 8'h00);
    tsb_bp_model_inst.send(1, 64);
    repeat (3) @(posedge clk);
    `CHK("irq set", 1'b1, irq)
    chk_rd("level", LV, 8'h21);
    av_wr(ST, 8'h80);
    chk_rd("slip left", ST, 8'h20);
    chk_rd("cleared", ST, 8'h00);
    `CHK("irq clear", 1'b0, irq)
    $display("overflow test done");
    av_wr(MK, 8'h00);
    for (int k = 0; k < 35; k++) begin
      rd_en <= (k < 34);
      @(posedge clk);
      if (k > 0 && k < 34) `CHK("data", 8'(k + 31), rbyte)
      if (k == 34) `CHK("replay", 8'h21, rbyte)
    end
    repeat (3) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    av_wr(MK, 8'he0);
    repeat (2) @(posedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    chk_rd("underflow", ST, 8'h60);
    `CHK("irq off", 1'b0, irq)
    $display("underflow test done");
    tsb_bp_model_inst.send(33, 65);
    chk_rd("refill", LV, 8'h40);
    tsb_bp_model_inst.send(32, 98);
    @(posedge clk);
    // Overflow event lands on the clearing edge of the status read
    fork
      chk_rd("collide", ST, 8'ha0);
      tsb_bp_model_inst.send(1, 130);
    join
    chk_rd("kept", ST, 8'ha0);
    `CHK("irq kept off", 1'b0, irq)
    $display("collision test done");
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK("irq reset", 1'b0, irq)
    `CHK("rdata reset", 8'h00, rbyte)
    chk_rd("level reset", LV, 8'h00);
    chk_rd("mask reset", MK, 8'h00);
    $display("second reset test done");
    finish_test();
  end
endmodule : tb_top
